// ===== design/timer_compare.sv
// Purpose: 8-bit timer with two compare channels, normal and clear-on-match
// Assumes: tick_in is a one-cycle prescaled pulse; port data and direction
//          come from the general port block
// Notes:   pwm waveforms are not generated; pwm modes only count, buffer and set flags
`timescale 1ns/1ps
`default_nettype none
module timer_compare
    import timer_cmp_pkg::*;
(
    input  wire logic             clk,           // 250 MHz system clock
    input  wire logic             sys_rst,       // async reset, high
    input  wire logic             wb_cyc_i,      // wishbone cycle
    input  wire logic             wb_stb_i,      // wishbone strobe
    input  wire logic             wb_we_i,       // write enable
    input  wire logic [ADR_W-1:0] wb_adr_i,      // byte address
    input  wire logic [3:0]       wb_sel_i,      // byte lanes
    input  wire logic [31:0]      wb_dat_i,      // write data
    output logic      [31:0]      wb_dat_o,      // read data
    output logic                  wb_ack_o,      // acknowledge
    input  wire logic             tick_in,       // prescaled tick pulse
    input  wire logic             irq_ack_a,     // match A interrupt serviced
    input  wire logic             irq_ack_b,     // match B interrupt serviced
    input  wire logic             irq_ack_ovf,   // overflow interrupt serviced
    output logic                  irq_match_a,   // match A request
    output logic                  irq_match_b,   // match B request
    output logic                  irq_overflow,  // overflow request
    input  wire logic [1:0]       port_data,     // general port values
    input  wire logic [1:0]       compare_pin_direction, // port direction bits
    output logic      [1:0]       pin_out,       // pin drive value
    output logic      [1:0]       pin_oe         // pin output enable
);

    // ****************************************
    // registers and wires
    // ****************************************
    bus_state_e       bus_state;
    logic [11:0]      control;
    logic [CNT_W-1:0] count_value;
    logic [2:0]       flags;
    logic [2:0]       int_en;
    logic             block_pending;
    logic [2:0]       waveform_mode_sel;
    logic [2:0]       clock_source_sel;
    logic [1:0]       compare_out_mode [2];
    logic             timer_tick;
    logic             hit_en;
    logic             pwm_mode;
    logic             wr_go;
    logic             lane0;
    logic             cnt_wr;
    logic             ctrl_wr;
    logic             flags_wr;
    logic             int_en_wr;
    logic             force_wr;
    logic [1:0]       cmp_wr;
    logic [1:0]       match;
    logic [1:0]       force_cmp;
    logic [1:0]       latch;
    logic [CNT_W-1:0] cmp_read [2];
    logic             wrap;
    logic             ctc_clear;
    logic [2:0]       flag_set;
    logic [2:0]       flag_clr;
    logic [31:0]      next_rdata;

    assign waveform_mode_sel   = control[CTRL_WAVE_LSB +: 3];
    assign clock_source_sel    = control[CTRL_CLKSRC_LSB +: 3];
    assign compare_out_mode[0] = control[CTRL_MODE_A_LSB +: 2];
    assign compare_out_mode[1] = control[CTRL_MODE_B_LSB +: 2];
    assign pwm_mode            = is_pwm(waveform_mode_sel);

    // ****************************************
    // wishbone slave
    // ****************************************
    // writes land on the edge where ack is high, as the master samples it
    assign wr_go     = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign lane0     = wr_go && wb_sel_i[0];
    assign ctrl_wr   = lane0 && (wb_adr_i == OFS_CONTROL);
    assign cnt_wr    = lane0 && (wb_adr_i == OFS_COUNT);
    assign cmp_wr[0] = lane0 && (wb_adr_i == OFS_COMPARE_A);
    assign cmp_wr[1] = lane0 && (wb_adr_i == OFS_COMPARE_B);
    assign flags_wr  = lane0 && (wb_adr_i == OFS_FLAGS);
    assign int_en_wr = lane0 && (wb_adr_i == OFS_INT_EN);
    assign force_wr  = lane0 && (wb_adr_i == OFS_FORCE);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_state <= BUS_IDLE;
        end else begin
            case (bus_state)
                BUS_IDLE: if (wb_cyc_i && wb_stb_i) bus_state <= BUS_ACK;
                BUS_ACK:  bus_state <= BUS_IDLE;
                default:  bus_state <= BUS_IDLE;
            endcase
        end
    end

    assign wb_ack_o = (bus_state == BUS_ACK);

    // control bits wider than one byte lane use lane 1 for the output modes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            control <= CTRL_RST;
        end else begin
            if (ctrl_wr) begin
                control[7:0] <= wb_dat_i[7:0];
            end
            if (wr_go && wb_sel_i[1] && wb_adr_i == OFS_CONTROL) begin
                control[11:8] <= wb_dat_i[11:8];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_en <= INT_EN_RST;
        end else if (int_en_wr) begin
            int_en <= wb_dat_i[2:0];
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            OFS_CONTROL:   next_rdata[11:0] = control;
            OFS_COUNT:     next_rdata[7:0] = count_value;
            OFS_COMPARE_A: next_rdata[7:0] = cmp_read[0];
            OFS_COMPARE_B: next_rdata[7:0] = cmp_read[1];
            OFS_FLAGS:     next_rdata[2:0] = flags;
            OFS_INT_EN:    next_rdata[2:0] = int_en;
            default:       next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_state == BUS_IDLE && wb_cyc_i && wb_stb_i) begin
            wb_dat_o <= next_rdata;
        end
    end

    // ****************************************
    // counter
    // ****************************************
    assign timer_tick = tick_in && (clock_source_sel != CLKSRC_STOPPED);
    assign hit_en     = timer_tick && !block_pending;
    assign wrap       = timer_tick && (count_value == COUNT_MAX);
    assign ctc_clear  = hit_en && match[0] && (waveform_mode_sel == WAVE_CLEAR_ON_MATCH);

    // a write arms the block even while stopped; the next tick consumes it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            block_pending <= 1'b0;
        end else if (cnt_wr) begin
            block_pending <= 1'b1;
        end else if (timer_tick) begin
            block_pending <= 1'b0;
        end
    end

    // sequence depends on waveform mode alone, never on output modes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_value <= COUNT_RST;
        end else if (cnt_wr) begin
            count_value <= wb_dat_i[7:0];
        end else if (ctc_clear) begin
            count_value <= COUNT_BOTTOM;
        end else if (timer_tick) begin
            count_value <= count_value + 8'h01;
        end
    end

    // ****************************************
    // compare channels
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            force_cmp <= 2'h0;
        end else begin
            force_cmp <= (force_wr && !pwm_mode) ? wb_dat_i[1:0] : 2'h0;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            compare_channel u_chan (
                .clk                  (clk),
                .sys_rst              (sys_rst),
                .count_value          (count_value),
                .cmp_wr               (cmp_wr[ch]),
                .cmp_wr_data          (wb_dat_i[7:0]),
                .pwm_mode             (pwm_mode),
                .buf_load             (wrap),
                .hit_en               (hit_en),
                .force_cmp            (force_cmp[ch]),
                .compare_out_mode     (compare_out_mode[ch]),
                .match                (match[ch]),
                .cmp_read             (cmp_read[ch]),
                .compare_output_latch (latch[ch])
            );
            assign pin_out[ch] = (compare_out_mode[ch] != OUT_NONE) ? latch[ch] : port_data[ch];
            assign pin_oe[ch]  = compare_pin_direction[ch];
        end
    endgenerate

    // ****************************************
    // flags and requests
    // ****************************************
    assign flag_set[FLAG_MATCH_A] = hit_en && match[0];
    assign flag_set[FLAG_MATCH_B] = hit_en && match[1];
    assign flag_set[FLAG_OVF]     = wrap && !cnt_wr && !ctc_clear;
    assign flag_clr[FLAG_MATCH_A] = irq_ack_a || (flags_wr && wb_dat_i[FLAG_MATCH_A]);
    assign flag_clr[FLAG_MATCH_B] = irq_ack_b || (flags_wr && wb_dat_i[FLAG_MATCH_B]);
    assign flag_clr[FLAG_OVF]     = irq_ack_ovf || (flags_wr && wb_dat_i[FLAG_OVF]);

    // a set in the same cycle as a clear wins
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags <= FLAGS_RST;
        end else begin
            flags <= flag_set | (flags & ~flag_clr);
        end
    end

    assign irq_match_a  = flags[FLAG_MATCH_A] && int_en[FLAG_MATCH_A];
    assign irq_match_b  = flags[FLAG_MATCH_B] && int_en[FLAG_MATCH_B];
    assign irq_overflow = flags[FLAG_OVF] && int_en[FLAG_OVF];

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_bus_answer: assert property (s_req |=> s_answer)
        else $error("wishbone ack not one cycle after request");
    a_match_flag: assert property (timer_tick && !block_pending && match[1] |=> flags[FLAG_MATCH_B])
        else $error("match flag not set on tick");
    a_flag_waits_tick: assert property (!flags[FLAG_MATCH_A] && !timer_tick |=> !flags[FLAG_MATCH_A])
        else $error("match flag set without tick");
    a_ack_clears: assert property (irq_ack_a && !(hit_en && match[0]) |=> !flags[FLAG_MATCH_A])
        else $error("serviced flag not cleared");
    a_blocked_tick: assert property (block_pending && timer_tick && !cnt_wr && force_cmp == 2'h0
                                     |=> $stable(latch) && !$rose(flags[FLAG_MATCH_A]))
        else $error("match not blocked after counter write");
    a_write_wins: assert property (cnt_wr |=> count_value == $past(wb_dat_i[7:0]))
        else $error("counter write lost");
    a_stopped_hold: assert property (clock_source_sel == CLKSRC_STOPPED && !cnt_wr |=> $stable(count_value))
        else $error("counter moved while stopped");
    a_normal_wrap: assert property (waveform_mode_sel == WAVE_NORMAL && wrap && !cnt_wr
                                    |=> count_value == COUNT_BOTTOM && flags[FLAG_OVF])
        else $error("normal wrap or overflow flag wrong");
    a_ctc_clear: assert property (ctc_clear && !cnt_wr |=> count_value == COUNT_BOTTOM)
        else $error("clear-on-match did not clear");
    a_pin_override: assert property (compare_out_mode[0] != OUT_NONE |-> pin_out[0] == latch[0])
        else $error("pin not overridden by latch");
    a_force_no_flag: assert property (force_cmp[1] && !(hit_en && match[1]) && !flags[FLAG_MATCH_B]
                                      |=> !flags[FLAG_MATCH_B])
        else $error("force set the match flag");

    // ****************************************
    // counting, flag and latch checks
    // ****************************************
    // a force shows two edges later: strobe register first, then the latch
    sequence s_force_set_a;
        force_wr && wb_dat_i[0] && !pwm_mode && compare_out_mode[0] == OUT_SET;
    endsequence
    sequence s_force_clear_b;
        force_wr && wb_dat_i[1] && !pwm_mode && compare_out_mode[1] == OUT_CLEAR;
    endsequence
    a_force_sets: assert property (s_force_set_a |=> ##1 latch[0])
        else $error("forced set did not reach latch A");
    a_force_clears: assert property (s_force_clear_b |=> ##1 !latch[1])
        else $error("forced clear did not reach latch B");
    a_match_a_flag: assert property (hit_en && match[0] |=> flags[FLAG_MATCH_A])
        else $error("match A flag not set on tick");
    a_write_clears: assert property (flags_wr && wb_dat_i[FLAG_MATCH_B] && !(hit_en && match[1])
                                     |=> !flags[FLAG_MATCH_B])
        else $error("written one did not clear flag B");
    a_ack_b_clears: assert property (irq_ack_b && !(hit_en && match[1]) |=> !flags[FLAG_MATCH_B])
        else $error("serviced flag B not cleared");
    a_ovf_service: assert property (irq_ack_ovf && !wrap |=> !flags[FLAG_OVF])
        else $error("serviced overflow flag not cleared");
    // hardware only sets the overflow flag; service or software clears it
    a_ovf_sticky: assert property (flags[FLAG_OVF] && !irq_ack_ovf && !(flags_wr && wb_dat_i[FLAG_OVF])
                                   |=> flags[FLAG_OVF])
        else $error("overflow flag dropped by hardware");
    a_ctc_wrap: assert property (waveform_mode_sel == WAVE_CLEAR_ON_MATCH && wrap && !cnt_wr && !ctc_clear
                                 |=> count_value == COUNT_BOTTOM && flags[FLAG_OVF])
        else $error("clear-on-match wrap or overflow wrong");
    // without a clear the count only steps up by one, whatever the output modes
    a_plain_step: assert property (timer_tick && !ctc_clear && !cnt_wr
                                   |=> count_value == $past(count_value) + 8'h01)
        else $error("count did not step by one");
    a_mode_keeps: assert property (ctrl_wr && !timer_tick && force_cmp == 2'h0 |=> $stable(latch))
        else $error("latch moved on a control write");
    a_port_value: assert property (compare_out_mode[1] == OUT_NONE |-> pin_out[1] == port_data[1])
        else $error("port value lost with mode zero");
    a_pwm_frozen: assert property (pwm_mode |=> $stable(latch))
        else $error("latch moved in a pwm mode");
    a_stopped_flag: assert property (clock_source_sel == CLKSRC_STOPPED && !flags[0] |=> !flags[0])
        else $error("match flag set while stopped");
    a_no_early_flag: assert property (!match[1] && !flags[FLAG_MATCH_B] |=> !flags[FLAG_MATCH_B])
        else $error("match B flag set without a match");

endmodule : timer_compare
`default_nettype wire

// ===== design/timer_cmp_pkg.sv
// Purpose: shared constants for the 8-bit timer compare block
// Assumes: classic Wishbone register access, 32-bit data, byte lanes 0 and 1 used
// Notes:   every offset, field position and software register reset value lives here once
package timer_cmp_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int CNT_W = 8;
    localparam int ADR_W = 8;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [ADR_W-1:0] OFS_CONTROL   = 8'h00;
    localparam logic [ADR_W-1:0] OFS_COUNT     = 8'h04;
    localparam logic [ADR_W-1:0] OFS_COMPARE_A = 8'h08;
    localparam logic [ADR_W-1:0] OFS_COMPARE_B = 8'h0c;
    localparam logic [ADR_W-1:0] OFS_FLAGS     = 8'h10;
    localparam logic [ADR_W-1:0] OFS_INT_EN    = 8'h14;
    localparam logic [ADR_W-1:0] OFS_FORCE     = 8'h18;

    // ****************************************
    // control register fields
    // ****************************************
    localparam int CTRL_WAVE_LSB   = 0;
    localparam int CTRL_CLKSRC_LSB = 3;
    localparam int CTRL_MODE_A_LSB = 8;
    localparam int CTRL_MODE_B_LSB = 10;
    localparam logic [11:0] CTRL_RST = 12'h000;

    // ****************************************
    // flag and enable bit positions, reset values and count limits
    // ****************************************
    localparam int FLAG_MATCH_A = 0;
    localparam int FLAG_MATCH_B = 1;
    localparam int FLAG_OVF     = 2;
    localparam logic [2:0] FLAGS_RST  = 3'h0;
    localparam logic [2:0] INT_EN_RST = 3'h0;
    localparam logic [CNT_W-1:0] COUNT_RST   = 8'h00;
    localparam logic [CNT_W-1:0] COMPARE_RST = 8'h00;
    localparam logic [CNT_W-1:0] COUNT_MAX   = 8'hff;
    localparam logic [CNT_W-1:0] COUNT_BOTTOM = 8'h00;

    // ****************************************
    // modes
    // ****************************************
    localparam logic [2:0] WAVE_NORMAL         = 3'h0;
    localparam logic [2:0] WAVE_CLEAR_ON_MATCH = 3'h2;
    localparam logic [2:0] CLKSRC_STOPPED      = 3'h0;

    localparam logic [1:0] OUT_NONE   = 2'h0;
    localparam logic [1:0] OUT_TOGGLE = 2'h1;
    localparam logic [1:0] OUT_CLEAR  = 2'h2;
    localparam logic [1:0] OUT_SET    = 2'h3;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_e;

    // odd waveform modes are the pwm family
    function automatic logic is_pwm(input logic [2:0] mode);
        is_pwm = mode[0];
    endfunction : is_pwm

endpackage : timer_cmp_pkg

// ===== design/compare_channel.sv
// Purpose: one output compare channel: compare value, buffer, comparator, latch
// Assumes: hit_en is a timer tick on which matches are not blocked
// Notes:   the output latch acts only in non-pwm modes
`timescale 1ns/1ps
`default_nettype none
module compare_channel
    import timer_cmp_pkg::*;
(
    input  wire logic             clk,                  // system clock
    input  wire logic             sys_rst,              // async reset, high
    input  wire logic [CNT_W-1:0] count_value,          // live count
    input  wire logic             cmp_wr,               // software writes compare
    input  wire logic [CNT_W-1:0] cmp_wr_data,          // value written
    input  wire logic             pwm_mode,             // pwm family selected
    input  wire logic             buf_load,             // tick with count at max (wrap)
    input  wire logic             hit_en,               // unblocked timer tick
    input  wire logic             force_cmp,            // force strobe pulse
    input  wire logic [1:0]       compare_out_mode,     // output action
    output logic                  match,                // count equals compare
    output logic      [CNT_W-1:0] cmp_read,             // software view
    output logic                  compare_output_latch  // internal latch
);

    logic [CNT_W-1:0] compare_value_chan;
    logic [CNT_W-1:0] cmp_buffer;
    logic             apply;

    assign match = (count_value == compare_value_chan);
    assign cmp_read = pwm_mode ? cmp_buffer : compare_value_chan;
    assign apply = !pwm_mode && ((hit_en && match) || force_cmp);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmp_buffer <= COMPARE_RST;
        end else if (cmp_wr) begin
            cmp_buffer <= cmp_wr_data;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            compare_value_chan <= COMPARE_RST;
        end else if (cmp_wr && !pwm_mode) begin
            compare_value_chan <= cmp_wr_data;
        end else if (pwm_mode && buf_load) begin
            compare_value_chan <= cmp_buffer;
        end
    end

    // mode is read live at the match, never buffered with the compare value
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            compare_output_latch <= 1'b0;
        end else if (apply) begin
            case (compare_out_mode)
                OUT_TOGGLE: compare_output_latch <= !compare_output_latch;
                OUT_CLEAR:  compare_output_latch <= 1'b0;
                OUT_SET:    compare_output_latch <= 1'b1;
                default:    compare_output_latch <= compare_output_latch;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_direct_write: assert property (cmp_wr && !pwm_mode |=> compare_value_chan == $past(cmp_wr_data))
        else $error("direct compare write not applied");
    a_toggle_on_hit: assert property (apply && compare_out_mode == OUT_TOGGLE
                                      |=> compare_output_latch != $past(compare_output_latch))
        else $error("latch did not toggle");
    a_mode_zero_hold: assert property (compare_out_mode == OUT_NONE && $stable(compare_out_mode)
                                       |=> $stable(compare_output_latch))
        else $error("latch changed with mode zero");

endmodule : compare_channel
`default_nettype wire

// ===== testbench/irq_service_model.sv
// Purpose: processor side interrupt service for the timer compare block
// Assumes: a request is a level; service is one acknowledge pulse
// Notes:   services only while svc_en is high, so flags can be inspected first
`timescale 1ns/1ps
`default_nettype none
module irq_service_model (
    input  wire logic clk,          // system clock
    input  wire logic sys_rst,      // async reset, high
    input  wire logic svc_en,       // service requests when high
    input  wire logic irq_match_a,  // match A request
    input  wire logic irq_match_b,  // match B request
    input  wire logic irq_overflow, // overflow request
    output var logic  irq_ack_a,    // match A serviced
    output var logic  irq_ack_b,    // match B serviced
    output var logic  irq_ack_ovf   // overflow serviced
);
    // one pulse per request; the gap lets the flag drop before a second look
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_ack_a   <= 1'b0;
            irq_ack_b   <= 1'b0;
            irq_ack_ovf <= 1'b0;
        end else begin
            irq_ack_a   <= svc_en & irq_match_a & ~irq_ack_a;
            irq_ack_b   <= svc_en & irq_match_b & ~irq_ack_b;
            irq_ack_ovf <= svc_en & irq_overflow & ~irq_ack_ovf;
        end
    end
endmodule : irq_service_model
`default_nettype wire

// ===== testbench/timer_compare_tb.sv
// Purpose: self-checking bench for the timer compare block
// Assumes: classic Wishbone, ack one cycle after the request is taken
// Notes:   ticks are single pulses driven by the bench
`timescale 1ns/1ps
`default_nettype none
module timer_compare_tb;
    import timer_cmp_pkg::*;
    logic clk, sys_rst, cyc, stb, we, tick_in, svc_en;
    logic [7:0] adr;
    logic [31:0] dat, wb_dat_o, rd;
    logic wb_ack_o, ack_a, ack_b, ack_o, irq_a, irq_b, irq_o;
    logic [1:0] port_data, pin_dir, pin_out, pin_oe;
    int fails, num_checks;
    logic [1:0] modes [5] = '{OUT_SET, OUT_TOGGLE, OUT_TOGGLE, OUT_CLEAR, OUT_SET};
    logic exp_l [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

    timer_compare dut_u (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .tick_in(tick_in), .irq_ack_a(ack_a), .irq_ack_b(ack_b), .irq_ack_ovf(ack_o),
        .irq_match_a(irq_a), .irq_match_b(irq_b), .irq_overflow(irq_o), .port_data(port_data),
        .compare_pin_direction(pin_dir), .pin_out(pin_out), .pin_oe(pin_oe));
    irq_service_model cpu_u (.clk(clk), .sys_rst(sys_rst), .svc_en(svc_en), .irq_match_a(irq_a),
        .irq_match_b(irq_b), .irq_overflow(irq_o), .irq_ack_a(ack_a), .irq_ack_b(ack_b),
        .irq_ack_ovf(ack_o));

    // ****************************************
    // bus, tick and compare helpers
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        // only the watchdog ends a wait for ack
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : xfer

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    task automatic tick(input int k);
        repeat (k) begin
            @(posedge clk);
            tick_in <= 1'b1;
            @(posedge clk);
            tick_in <= 1'b0;
        end
    endtask : tick

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done

    initial begin
        #20000;
        fails++;
        test_done();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        sys_rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0;
        tick_in = 1'b0; svc_en = 1'b0; port_data = 2'b10; pin_dir = 2'b11;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        rdchk(OFS_CONTROL, 32'h0);
        rdchk(8'h40, 32'h0);
        chk({30'h0, pin_out}, 32'h2);
        chk({30'h0, pin_oe}, 32'h3);
        xfer(1'b1, OFS_CONTROL, 32'h500);
        @(posedge clk);
        chk({30'h0, pin_out}, 32'h0);
        $display("reset test done");
        xfer(1'b1, OFS_INT_EN, 32'h7);
        xfer(1'b1, OFS_COMPARE_A, 32'h3);
        xfer(1'b1, OFS_CONTROL, 32'h8);
        xfer(1'b1, OFS_COUNT, 32'h1);
        tick(3);
        rdchk(OFS_COUNT, 32'h4);
        rdchk(OFS_FLAGS, 32'h1);
        chk({31'h0, irq_a}, 32'h1);
        chk({30'h0, irq_b, irq_o}, 32'h0);
        xfer(1'b1, OFS_FLAGS, 32'h1);
        rdchk(OFS_FLAGS, 32'h0);
        xfer(1'b1, OFS_COUNT, 32'h3);
        tick(1);
        rdchk(OFS_FLAGS, 32'h0);
        $display("match test done");
        xfer(1'b1, OFS_COUNT, 32'hff);
        tick(1);
        rdchk(OFS_COUNT, 32'h0);
        rdchk(OFS_FLAGS, 32'h4);
        svc_en <= 1'b1;
        repeat (4) @(posedge clk);
        rdchk(OFS_FLAGS, 32'h0);
        svc_en <= 1'b0;
        $display("overflow test done");
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, OFS_CONTROL, 32'h8 | (32'(modes[i]) << CTRL_MODE_A_LSB));
            xfer(1'b1, OFS_FORCE, 32'h1);
            repeat (2) @(posedge clk);
            chk({31'h0, pin_out[0]}, {31'h0, exp_l[i]});
        end
        rdchk(OFS_FLAGS, 32'h0);
        rdchk(OFS_COUNT, 32'h0);
        $display("force test done");
        xfer(1'b1, OFS_COMPARE_A, 32'h2);
        xfer(1'b1, OFS_CONTROL, 32'h8 | WAVE_CLEAR_ON_MATCH | (32'(OUT_TOGGLE) << CTRL_MODE_A_LSB));
        @(posedge clk);
        chk({31'h0, pin_out[0]}, 32'h1);
        xfer(1'b1, OFS_COUNT, 32'h0);
        tick(3);
        rdchk(OFS_COUNT, 32'h0);
        chk({31'h0, pin_out[0]}, 32'h0);
        tick(3);
        @(posedge clk);
        chk({31'h0, pin_out[0]}, 32'h1);
        xfer(1'b1, OFS_CONTROL, 32'h8 | WAVE_CLEAR_ON_MATCH);
        tick(3);
        xfer(1'b1, OFS_CONTROL, 32'(WAVE_CLEAR_ON_MATCH) | (32'(OUT_TOGGLE) << CTRL_MODE_A_LSB));
        @(posedge clk);
        chk({30'h0, pin_out}, 32'h3);
        tick(2);
        rdchk(OFS_COUNT, 32'h0);
        $display("clear on match test done");
        test_done();
    end
endmodule : timer_compare_tb
`default_nettype wire
